// *** logic/dmaac_channel.sv ***
// What this block does
// (R1) Select bits 0xx pick timer event 0..3.
// (R2) Select 100 transmit-empty, 101 receive-full event.
// (R3) First select bits 2:1 both one: full mode.
// (R4) Serial 0 feeds channels 0-1, serial 1 feeds 2-3.
// (R5) Second half 110 pin falling, 111 pin low.
// (R6) Shared event activates every channel; priority arbiter serves.
// (R7) Enabled channel blocks its source's CPU interrupt.
// (R8) Full mode: first address source, second destination.
// (R9) Address top byte reads ones, ignores writes.
// (R10) Addresses and counts untouched by reset, standby.
// (R11) Fixed peripheral address unused in full mode.
// (R12) Normal: 16-bit count decrements, ends at zero.
// (R13) Block: upper byte counts units, reloads from lower.
// (R14) Block: block count decrements per block, ends.
// (R15) Software loads equal upper and lower size bytes.
// (R16) First control register resets to zero.
// (R17) Run needs master and transfer enable; auto starts.
// (R18) Completion clears transfer enable; disabled ignores requests.
// (R19) Enable bits set only after read seeing zero.
// (R20) Completion with interrupt enabled raises end irq; a software clear of the enable does not.
// (R21) Control bit 6: byte or word unit.
// (R22) Bit 4 steps source, bit 5 direction, 1/2.
// (R23) First select bit 0: normal or block mode.
// (R24) Non-maskable interrupt clears master enable, suspending.
// (R25) Control bit 3 enables end interrupt.
// (R26) Each event occurrence is one request; the code keeps one pending flag, so repeats before block end merge.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "dmaac_cfg.svh"
module dmaac_channel
    import dmaac_pkg::*;
#(
    parameter int CHANNEL = 0
) (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        standby,
    input  wire logic        nmi,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Activation events.
    input  wire logic [3:0]  timer_unit_event,
    input  wire logic [1:0]  serial_port_tx_empty,
    input  wire logic [1:0]  serial_port_rx_full,
    input  wire logic        external_request_pin_n,
    // Short mode activations and interrupt blocking.
    output logic             act_first,
    output logic             act_second,
    output logic      [7:0]  event_irq_block,
    // Full mode bus requests.
    output logic             dma_req,
    input  wire logic        bus_grant,
    output logic             xfer_strobe,
    output logic      [31:0] xfer_src,
    output logic      [31:0] xfer_dst,
    output logic             xfer_word,
    output logic             transfer_end_irq
);
    logic [23:0]  source_address;
    logic [23:0]  destination_address;
    logic [15:0]  transfer_or_block_size_count;
    logic [15:0]  block_count;
    logic [7:0]   channel_control_first;
    logic [7:0]   channel_control_second;
    logic         enable_armed;
    logic         master_armed;
    logic         end_flag;
    logic         pending;
    logic         pin_s1;
    logic         pin_s2;
    logic         pin_s3;
    dmaac_mode_t  mode;
    logic         access;
    logic         wr;
    logic         rd;
    logic         enabled;
    logic         want;
    logic         unit_go;
    logic         block_end;
    logic         last_unit;
    logic         full_event;
    logic         auto_req;
    logic         pin_fall;
    logic         pin_low;
    logic [23:0]  step;

    localparam logic SERIAL_IDX = (CHANNEL >= 2);

    // Claims at most one source bit (none for 11x): timers 0..3, transmit 4..5, receive 6..7.
    function automatic logic [7:0] claim(input logic [2:0] sel,
                                         input logic       second);
        logic [7:0] c;
        c = 8'h00;
        if (!sel[2]) begin
            c[sel[1:0]] = 1'b1;  // see (R1)
        end else if (!sel[1]) begin
            if (!sel[0]) begin
                c[4 + SERIAL_IDX] = 1'b1;  // see (R2) see (R4)
            end else begin
                c[6 + SERIAL_IDX] = 1'b1;  // see (R2) see (R4)
            end
        end
        return c;
    endfunction : claim

    function automatic logic half_event(input logic [2:0] sel,
                                        input logic       second,
                                        input logic [7:0] ev,
                                        input logic       fall,
                                        input logic       low);
        logic e;
        e = |(claim(sel, second) & ev);
        if (second && sel[2:1] == 2'b11) begin
            e = sel[0] ? low : fall;  // see (R5)
        end
        return e;
    endfunction : half_event

    assign access  = psel && penable && pready;
    assign wr      = access && pwrite;
    assign rd      = access && !pwrite;
    assign pin_fall = pin_s3 && !pin_s2;
    assign pin_low  = !pin_s2;

    always_comb begin
        if (channel_control_first[2:1] != 2'b11) begin
            mode = DMAAC_SHORT;
        end else if (channel_control_first[0]) begin
            mode = DMAAC_BLOCK;  // see (R23)
        end else begin
            mode = DMAAC_NORMAL;  // see (R3)
        end
    end

    // Both enable bits are needed; either one alone holds the channel.
    assign enabled = (mode != DMAAC_SHORT)
                     && channel_control_first[`DMAAC_BIT_ENABLE]
                     && channel_control_second[`DMAAC_BIT_ENABLE];  // see (R17)

    always_comb begin
        full_event = 1'b0;
        auto_req   = 1'b0;
        case (mode)
            DMAAC_NORMAL: begin
                auto_req = channel_control_second[2:0] == `DMAAC_SEL_AUTO_B
                        || channel_control_second[2:0] == `DMAAC_SEL_AUTO_C
                        || (channel_control_second[2:0] == `DMAAC_SEL_LOW
                            && pin_low);
                full_event = channel_control_second[2:0] == `DMAAC_SEL_FALL
                             && pin_fall;
            end
            DMAAC_BLOCK: begin
                full_event = !channel_control_second[2]
                    && timer_unit_event[channel_control_second[1:0]];
            end
            default: begin
                full_event = 1'b0;
                auto_req   = 1'b0;
            end
        endcase
    end

    assign want      = enabled && (auto_req || pending);  // see (R17)
    assign unit_go   = dma_req && bus_grant && enabled;
    assign block_end = (mode == DMAAC_NORMAL)
                       || transfer_or_block_size_count[15:8] == 8'h01;
    assign last_unit = (mode == DMAAC_NORMAL)
                     ? transfer_or_block_size_count == 16'h0001  // see (R12)
                     : block_end && block_count == 16'h0001;  // see (R14)
    assign step = channel_control_first[`DMAAC_BIT_SIZE] ? 24'h000002
                                                         : 24'h000001;

    // The second and third flops feed the edge detector.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
            pin_s3 <= 1'b1;
        end else begin
            pin_s1 <= external_request_pin_n;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // No reset here on purpose: software must load these before use.
    always_ff @(posedge sys_clk) begin  // see (R10)
        if (wr && paddr == `DMAAC_OFF_SRC) begin
            source_address <= pwdata[23:0];  // see (R9)
        end else if (unit_go && channel_control_first[`DMAAC_BIT_STEP]) begin
            if (channel_control_first[`DMAAC_BIT_DIR]) begin
                source_address <= source_address - step;  // see (R22)
            end else begin
                source_address <= source_address + step;  // see (R22)
            end
        end
        if (wr && paddr == `DMAAC_OFF_DST) begin
            destination_address <= pwdata[23:0];  // see (R9)
        end
        if (wr && paddr == `DMAAC_OFF_CNT_A) begin
            transfer_or_block_size_count <= pwdata[15:0];
        end else if (unit_go && mode == DMAAC_NORMAL) begin
            transfer_or_block_size_count <=
                transfer_or_block_size_count - 16'h0001;  // see (R12)
        end else if (unit_go && block_end) begin
            transfer_or_block_size_count[15:8] <=
                transfer_or_block_size_count[7:0];  // see (R13)
        end else if (unit_go) begin
            transfer_or_block_size_count[15:8] <=
                transfer_or_block_size_count[15:8] - 8'h01;  // see (R13)
        end
        if (wr && paddr == `DMAAC_OFF_CNT_B) begin
            block_count <= pwdata[15:0];
        end else if (unit_go && mode == DMAAC_BLOCK && block_end) begin
            block_count <= block_count - 16'h0001;  // see (R14)
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            channel_control_first <= `DMAAC_CTRL_RESET;  // see (R16)
            enable_armed          <= 1'b0;
        end else if (standby) begin
            channel_control_first <= `DMAAC_CTRL_RESET;  // see (R16)
            enable_armed          <= 1'b0;
        end else begin
            if (rd && paddr == `DMAAC_OFF_CTRL_A
                && !channel_control_first[`DMAAC_BIT_ENABLE]) begin
                enable_armed <= 1'b1;  // see (R19)
            end else if (wr && paddr == `DMAAC_OFF_CTRL_A) begin
                enable_armed <= 1'b0;
            end
            if (wr && paddr == `DMAAC_OFF_CTRL_A) begin
                channel_control_first[6:0] <= pwdata[6:0];  // see (R21) (R25)
                if (!pwdata[7]) begin
                    channel_control_first[7] <= 1'b0;
                end else if (enable_armed) begin
                    channel_control_first[7] <= 1'b1;  // see (R19)
                end
            end else if (unit_go && last_unit) begin
                channel_control_first[7] <= 1'b0;  // see (R18)
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            channel_control_second <= `DMAAC_CTRL_RESET;
            master_armed           <= 1'b0;
        end else if (standby) begin
            channel_control_second <= `DMAAC_CTRL_RESET;
            master_armed           <= 1'b0;
        end else begin
            if (rd && paddr == `DMAAC_OFF_CTRL_B
                && !channel_control_second[`DMAAC_BIT_ENABLE]) begin
                master_armed <= 1'b1;
            end else if (wr && paddr == `DMAAC_OFF_CTRL_B) begin
                master_armed <= 1'b0;
            end
            if (wr && paddr == `DMAAC_OFF_CTRL_B) begin
                channel_control_second[6:0] <= pwdata[6:0];
            end
            if (nmi) begin
                channel_control_second[7] <= 1'b0;  // see (R24)
            end else if (wr && paddr == `DMAAC_OFF_CTRL_B) begin
                if (!pwdata[7]) begin
                    channel_control_second[7] <= 1'b0;
                end else if (master_armed) begin
                    channel_control_second[7] <= 1'b1;  // see (R24)
                end
            end
        end
    end

    // A new occurrence beats the block-end clear in the same cycle; one that arrives while pending is already set merges with it.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pending <= 1'b0;
        end else if (standby || !channel_control_first[`DMAAC_BIT_ENABLE]) begin
            pending <= 1'b0;  // see (R18)
        end else if (full_event) begin
            pending <= 1'b1;  // see (R26) see (R6)
        end else if (unit_go && block_end) begin
            pending <= 1'b0;  // see (R26)
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            end_flag         <= 1'b0;
            transfer_end_irq <= 1'b0;
        end else begin
            if (unit_go && last_unit) begin
                end_flag <= 1'b1;
            end else if (channel_control_first[`DMAAC_BIT_ENABLE] || standby) begin
                end_flag <= 1'b0;
            end
            transfer_end_irq <= end_flag
                && channel_control_first[`DMAAC_BIT_IE];  // see (R20) (R25)
        end
    end

    // The fixed peripheral address never enters full mode moves.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dma_req     <= 1'b0;
            xfer_strobe <= 1'b0;
            xfer_src    <= 32'h00000000;
            xfer_dst    <= 32'h00000000;
            xfer_word   <= 1'b0;
        end else begin
            dma_req     <= want && !unit_go && !nmi;  // see (R17) (R6)
            xfer_strobe <= unit_go;
            if (unit_go) begin
                xfer_src  <= {`DMAAC_TOP_BYTE, source_address};  // see (R8)
                xfer_dst  <= {`DMAAC_TOP_BYTE, destination_address};  // see (R11)
                xfer_word <= channel_control_first[`DMAAC_BIT_SIZE];  // see (R21)
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            act_first       <= 1'b0;
            act_second      <= 1'b0;
            event_irq_block <= 8'h00;
        end else begin
            act_first  <= mode == DMAAC_SHORT
                && channel_control_first[`DMAAC_BIT_ENABLE]
                && half_event(channel_control_first[2:0], 1'b0,
                   {serial_port_rx_full, serial_port_tx_empty,
                    timer_unit_event}, pin_fall, pin_low);  // see (R1) (R2)
            act_second <= mode == DMAAC_SHORT
                && channel_control_second[`DMAAC_BIT_ENABLE]
                && half_event(channel_control_second[2:0], 1'b1,
                   {serial_port_rx_full, serial_port_tx_empty,
                    timer_unit_event}, pin_fall, pin_low);  // see (R5)
            event_irq_block <=
                ((mode == DMAAC_SHORT
                  && channel_control_first[`DMAAC_BIT_ENABLE])
                 ? claim(channel_control_first[2:0], 1'b0) : 8'h00)
              | ((mode == DMAAC_SHORT
                  && channel_control_second[`DMAAC_BIT_ENABLE])
                 ? claim(channel_control_second[2:0], 1'b1) : 8'h00)
              | ((mode == DMAAC_BLOCK
                  && channel_control_first[`DMAAC_BIT_ENABLE])
                 ? claim(channel_control_second[2:0], 1'b1) : 8'h00);  // see (R7)
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && paddr > `DMAAC_OFF_STATUS;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `DMAAC_OFF_SRC:    prdata <= {`DMAAC_TOP_BYTE,
                                                  source_address};  // see (R9)
                    `DMAAC_OFF_DST:    prdata <= {`DMAAC_TOP_BYTE,
                                                  destination_address};
                    `DMAAC_OFF_CNT_A:  prdata <= {16'h0000,
                                            transfer_or_block_size_count};
                    `DMAAC_OFF_CNT_B:  prdata <= {16'h0000, block_count};
                    `DMAAC_OFF_CTRL_A: prdata <= {24'h000000,
                                                  channel_control_first};
                    `DMAAC_OFF_CTRL_B: prdata <= {24'h000000,
                                                  channel_control_second};
                    `DMAAC_OFF_STATUS: prdata <= {28'h0000000, end_flag,
                                                  pending, enabled, dma_req};
                    default:           prdata <= 32'h00000000;
                endcase
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_enable_needs_read: assert property (  // see (R19)
        $rose(channel_control_first[7]) |-> $past(enable_armed))
        else $error("transfer enable set without prior read");
    a_end_clears_enable: assert property (  // see (R18)
        unit_go && last_unit |=> !channel_control_first[7])
        else $error("transfer enable not cleared at end");
    a_end_irq_raise: assert property (  // see (R20)
        unit_go && last_unit && channel_control_first[3] && !standby
        && !(wr && paddr == `DMAAC_OFF_CTRL_A) |=> ##1 transfer_end_irq)
        else $error("end interrupt missing");
    a_nmi_stops_master: assert property (  // see (R24)
        nmi |=> !channel_control_second[7] && !dma_req)
        else $error("master enable survived nmi");
    a_no_req_disabled: assert property (  // see (R17)
        !enabled |=> !dma_req)
        else $error("request while disabled");
    a_src_step_up: assert property (  // see (R22)
        unit_go && channel_control_first[5:4] == 2'b01
        && !(wr && paddr == `DMAAC_OFF_SRC)
        |=> source_address == $past(source_address) + $past(step))
        else $error("source address step wrong");
    a_block_reload: assert property (  // see (R13)
        unit_go && mode == DMAAC_BLOCK && block_end
        && !(wr && paddr == `DMAAC_OFF_CNT_A)
        |=> transfer_or_block_size_count[15:8]
            == $past(transfer_or_block_size_count[7:0]))
        else $error("block size not reloaded");
    a_normal_count: assert property (  // see (R12)
        unit_go && mode == DMAAC_NORMAL
        && !(wr && paddr == `DMAAC_OFF_CNT_A)
        |=> transfer_or_block_size_count
            == $past(transfer_or_block_size_count) - 16'h0001)
        else $error("normal count not decremented");
    a_full_no_short: assert property (  // see (R3)
        mode != DMAAC_SHORT |=> !act_first)
        else $error("short activation in full mode");
    a_pending_held: assert property (  // see (R6)
        pending && !unit_go && !standby && channel_control_first[7]
        |=> pending)
        else $error("pending request lost");
endmodule : dmaac_channel

// *** logic/dmaac_cfg.svh ***
`ifndef DMAAC_CFG_SVH
`define DMAAC_CFG_SVH
`define DMAAC_OFF_SRC      8'h00
`define DMAAC_OFF_DST      8'h04
`define DMAAC_OFF_CNT_A    8'h08
`define DMAAC_OFF_CNT_B    8'h0c
`define DMAAC_OFF_CTRL_A   8'h10
`define DMAAC_OFF_CTRL_B   8'h14
`define DMAAC_OFF_STATUS   8'h18
`define DMAAC_CTRL_RESET   8'h00
`define DMAAC_TOP_BYTE     8'hff
`define DMAAC_BIT_ENABLE   7
`define DMAAC_BIT_SIZE     6
`define DMAAC_BIT_DIR      5
`define DMAAC_BIT_STEP     4
`define DMAAC_BIT_IE       3
`define DMAAC_SEL_AUTO_B   3'h0
`define DMAAC_SEL_AUTO_C   3'h2
`define DMAAC_SEL_FALL     3'h6
`define DMAAC_SEL_LOW      3'h7
`endif

// *** logic/dmaac_pkg.sv ***
package dmaac_pkg;
    typedef enum logic [1:0] {
        DMAAC_SHORT  = 2'b00,
        DMAAC_NORMAL = 2'b01,
        DMAAC_BLOCK  = 2'b10
    } dmaac_mode_t;
endpackage : dmaac_pkg

// *** tb/dmaac_arbiter_model.sv ***
`timescale 1ns/10ps
module dmaac_arbiter_model (
    // Clock and reset.
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // Request and grant.
    input  wire logic slow,
    input  wire logic dma_req,
    output logic      bus_grant
);
    logic [1:0] wait_cnt;

    // A slow arbiter holds a request off three cycles, as a busy bus would.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_cnt  <= 2'h0;
            bus_grant <= 1'b0;
        end else begin
            bus_grant <= dma_req && !bus_grant && (!slow || wait_cnt == 2'h3);
            wait_cnt  <= (dma_req && !bus_grant) ? wait_cnt + 2'h1 : 2'h0;
        end
    end
endmodule : dmaac_arbiter_model

// *** tb/dmaac_channel_tb_top.sv ***
`timescale 1ns/10ps
`include "dmaac_cfg.svh"
module dmaac_channel_tb_top;
    import dmaac_pkg::*;
    logic        sys_clk, sys_rst, standby, nmi, slow, ext_n;
    logic        psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr, event_irq_block;
    logic [31:0] pwdata, prdata, rd, xfer_src, xfer_dst, last_src, last_dst;
    logic [3:0]  timer_ev;
    logic [1:0]  tx_empty, rx_full;
    logic        act_first, act_second, dma_req, bus_grant, xfer_strobe;
    logic        xfer_word, last_word, transfer_end_irq;
    int          num_errors, total_checks, n_act, n_act2, n_xfer, cyc;

    dmaac_channel #(.CHANNEL(0)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .standby(standby), .nmi(nmi),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_unit_event(timer_ev),
        .serial_port_tx_empty(tx_empty), .serial_port_rx_full(rx_full),
        .external_request_pin_n(ext_n), .act_first(act_first),
        .act_second(act_second), .event_irq_block(event_irq_block),
        .dma_req(dma_req), .bus_grant(bus_grant),
        .xfer_strobe(xfer_strobe), .xfer_src(xfer_src),
        .xfer_dst(xfer_dst), .xfer_word(xfer_word),
        .transfer_end_irq(transfer_end_irq));
    dmaac_arbiter_model arb (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .slow(slow), .dma_req(dma_req), .bus_grant(bus_grant));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Outputs are read at the edge, before that edge's updates land.
    always @(posedge sys_clk) begin
        cyc++;
        if (act_first === 1'b1) n_act++;
        if (act_second === 1'b1) n_act2++;
        if (xfer_strobe === 1'b1) begin
            n_xfer++;
            last_src  = xfer_src;
            last_dst  = xfer_dst;
            last_word = xfer_word;
        end
        if (cyc == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait that never sees pready.
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    // Clearing first makes the read see the enable at zero, so the set holds.
    task automatic set_ctrl(input logic [7:0] a, input logic [31:0] v);
        apb(1'b1, a, 32'h0);
        apb(1'b0, a, 32'h0);
        apb(1'b1, a, v);
    endtask : set_ctrl

    task automatic pulse(input logic [7:0] v);
        {rx_full, tx_empty, timer_ev} <= v;
        @(posedge sys_clk);
        {rx_full, tx_empty, timer_ev} <= 8'h00;
        repeat (6) @(posedge sys_clk);
    endtask : pulse

    task automatic t_regs();
        apb(1'b0, `DMAAC_OFF_CTRL_A, 32'h0);
        chk("ctrl_first reset", 32'h0, rd);
        apb(1'b1, `DMAAC_OFF_SRC, 32'h12345678);
        apb(1'b0, `DMAAC_OFF_SRC, 32'h0);
        chk("source top byte", 32'hff345678, rd);
        // The reset read above armed the enable; a write disarms it.
        apb(1'b1, `DMAAC_OFF_CTRL_A, 32'h0);
        apb(1'b1, `DMAAC_OFF_CTRL_A, 32'h86);
        apb(1'b0, `DMAAC_OFF_CTRL_A, 32'h0);
        chk("enable without read", 32'h06, rd);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        $display("test regs done");
    endtask : t_regs

    task automatic t_act(input logic [2:0] sel, input logic [7:0] bad,
                         input logic [7:0] good);
        set_ctrl(`DMAAC_OFF_CTRL_A, {24'h0, 5'h10, sel});
        n_act = 0;
        pulse(bad);
        chk("foreign event", 32'h0, n_act);
        pulse(good);
        chk("activations", 32'h1, n_act);
        chk("irq blocked", {24'h0, good},
            {24'h0, event_irq_block & good});
        $display("test source %0d done", sel);
    endtask : t_act

    task automatic t_run(input logic [7:0] ctl, input logic slw, input int n,
                         input int inc, input int blocks, input logic brk);
        int k;
        int units;
        units = ctl[0] ? n * blocks : n;
        slow <= slw;
        apb(1'b1, `DMAAC_OFF_DST, 32'h00002000);
        apb(1'b1, `DMAAC_OFF_CNT_A,
            ctl[0] ? {16'h0, n[7:0], n[7:0]} : n);
        apb(1'b1, `DMAAC_OFF_CNT_B, blocks);
        apb(1'b1, `DMAAC_OFF_SRC, 32'h00001000);
        n_xfer = 0;
        set_ctrl(`DMAAC_OFF_CTRL_A, {24'h0, ctl});
        if (ctl[0]) repeat (blocks) pulse(8'h01);
        if (brk) begin
            k = 0;
            while (n_xfer == 0 && k < 100) begin
                @(posedge sys_clk);
                k++;
            end
            nmi <= 1'b1;
            @(posedge sys_clk);
            nmi <= 1'b0;
            repeat (2) @(posedge sys_clk);
            k = n_xfer;
            repeat (20) @(posedge sys_clk);
            chk("held by nmi", k, n_xfer);
            set_ctrl(`DMAAC_OFF_CTRL_B, 32'h80);
        end
        k = 0;
        do begin
            apb(1'b0, `DMAAC_OFF_STATUS, 32'h0);
            k++;
        end while (rd[1] === 1'b1 && k < 200);
        repeat (3) @(posedge sys_clk);
        chk("unit count", units, n_xfer);
        chk("last source", 32'hff000000 | (32'h1000 + (units - 1) * inc),
            last_src);
        chk("destination", 32'hff002000, last_dst);
        chk("unit size", {31'h0, ctl[6]}, {31'h0, last_word});
        chk("end irq", {31'h0, ctl[3]},
            {31'h0, transfer_end_irq});
        apb(1'b0, `DMAAC_OFF_CTRL_A, 32'h0);
        chk("enable cleared", {24'h0, ctl & 8'h7f}, rd);
        $display("test run %h done", ctl);
    endtask : t_run

    initial begin
        {sys_rst, standby, nmi, slow, ext_n} = 5'b10001;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {timer_ev, tx_empty, rx_full} = '0;
        {num_errors, total_checks, n_act, n_act2, n_xfer, cyc} = '0;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        t_regs();
        set_ctrl(`DMAAC_OFF_CTRL_B, 32'h80);
        for (int i = 0; i < 4; i++)
            t_act(i[2:0], 8'h0f & ~(8'h1 << i), 8'h1 << i);
        t_act(3'h4, 8'h20, 8'h10);
        t_act(3'h5, 8'h80, 8'h40);
        set_ctrl(`DMAAC_OFF_CTRL_B, 32'h86);
        n_act2 = 0;
        ext_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        ext_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk("pin falling edge", 32'h1, n_act2);
        $display("test pin done");
        set_ctrl(`DMAAC_OFF_CTRL_B, 32'h80);
        t_run(8'h9e, 1'b0, 3, 1, 1, 1'b0);
        t_run(8'hfe, 1'b1, 2, -2, 1, 1'b0);
        t_run(8'h86, 1'b0, 1, 0, 1, 1'b0);
        t_run(8'h9f, 1'b0, 2, 1, 2, 1'b0);
        t_run(8'h96, 1'b1, 4, 1, 1, 1'b1);
        wrap_up();
    end
endmodule : dmaac_channel_tb_top
